// >>> core/dvo_pkg.sv
// shared constants, types and helpers of the pixel output formatter
`default_nettype none
package dvo_pkg;
    // apb decode and register layout
    localparam int unsigned ADDR_W         = 8;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam int unsigned CTRL_TWO_BIT   = 0;
    localparam int unsigned CTRL_STAGGER_SELECT_N_BIT  = 1;
    localparam int unsigned CTRL_PDO_BIT   = 2;
    localparam int unsigned CTRL_W         = 3;
    localparam logic [2:0]  CTRL_RESET     = 3'h6;
    localparam int unsigned STAT_LINK_BIT  = 0;
    // recovered channel word: byte in [7:0], control pair above it
    localparam int unsigned CH_W           = 10;
    localparam int unsigned CH_C0_BIT      = 8;
    localparam int unsigned CH_C1_BIT      = 9;
    // link-idle window: time in ns and its count of pclk cycles
    localparam int unsigned PCLK_MHZ       = 200;
    localparam int unsigned LINK_IDLE_NS   = 100000;
    localparam int unsigned LINK_IDLE_CYC  = (LINK_IDLE_NS * PCLK_MHZ) / 1000;

    // pairing phase of the link-side packer
    typedef enum {PH_EVEN, PH_ODD} dvo_phase_t;

    // one output update as it crosses from the link domain
    typedef struct packed {
        logic        two_pix;
        logic        stagger_select_n_n;
        logic        de;
        logic        hsync;
        logic        vsync;
        logic        ctl1;
        logic        ctl2;
        logic [23:0] odd;
        logic [23:0] even;
    } dvo_word_t;

    // blue in the low byte, green in the middle, red on top
    function automatic logic [23:0] dvo_pack_pixel(input logic [7:0] b,
                                                   input logic [7:0] g,
                                                   input logic [7:0] r);
        return {r, g, b};
    endfunction : dvo_pack_pixel
endpackage : dvo_pkg
`default_nettype wire

// >>> core/dvo_cfg_if.sv
// configuration and status carried between register file and core
`timescale 1ns/1ps
`default_nettype none
interface dvo_cfg_if;
    logic two_pix;
    logic stagger_select_n_n;
    logic pdo_n;
    logic link_active;
    modport regs (output two_pix, output stagger_select_n_n, output pdo_n, input link_active);
    modport core (input two_pix, input stagger_select_n_n, input pdo_n, output link_active);
endinterface : dvo_cfg_if
`default_nettype wire

// >>> core/dvo_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dvo_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : dvo_sync
`default_nettype wire

// >>> core/dvo_apb_regs.sv
// apb slave holding the control and status words
`timescale 1ns/1ps
`default_nettype none
module dvo_apb_regs (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dvo_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    dvo_cfg_if.regs                        cfg
);
    import dvo_pkg::*;

    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              hit_ctrl;
    logic              hit_stat;

    assign hit_ctrl = (paddr == REG_CTRL);
    assign hit_stat = (paddr == REG_STATUS);

    // one wait state, then answer; write lands on the sampling edge
    always_comb begin
        next_ctrl    = ctrl;
        next_prdata  = prdata;
        next_pslverr = pslverr;
        next_pready  = psel && penable && !pready;
        if (next_pready) begin
            next_pslverr = !(hit_ctrl || hit_stat);
            next_prdata  = 32'h0;
            if (hit_ctrl) begin
                next_prdata[CTRL_W-1:0] = ctrl;
            end
            if (hit_stat) begin
                next_prdata[STAT_LINK_BIT] = cfg.link_active;
            end
        end
        if (psel && penable && pready && pwrite && hit_ctrl && pstrb[0]) begin
            next_ctrl = pwdata[CTRL_W-1:0];
        end
    end

    // register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= CTRL_RESET;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign cfg.two_pix = ctrl[CTRL_TWO_BIT];
    assign cfg.stagger_select_n_n  = ctrl[CTRL_STAGGER_SELECT_N_BIT];
    assign cfg.pdo_n   = ctrl[CTRL_PDO_BIT];

    // access phase is answered on its second cycle
    chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer not given after one wait state");

    cov_ctrl_write: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && hit_ctrl);
endmodule : dvo_apb_regs
`default_nettype wire

// >>> core/dvo_formatter.sv
// dvi receiver pixel output formatter: pairing, stagger, link activity
// Overview of operation
// - one-pixel mode: even then odd on even bus
// - two-pixel mode: even bus carries even pixel only
// - odd bus zero in one-pixel mode, else odd
// - all pixel outputs launched with output clock
// - channel zero: blue, blanking gives hsync vsync
// - channel one: green, blanking gives ctl1
// - channel two: red, blanking gives ctl2
// - link flag high while de switches, else low
// - link flag derived from recovered de only
// - stagger low in two-pixel mode offsets buses
// - stagger high: both buses update together
// - select high two pixels, low one pixel
// - output powerdown disables drivers except flag, ctl1
// - output clock period one or two pixel times
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dvo_formatter #(
    parameter int IDLE_CYC = dvo_pkg::LINK_IDLE_CYC,
    parameter int CNT_W    = 8
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       link_clock_input,
    input  wire logic [dvo_pkg::CH_W-1:0]   channel_zero_input,
    input  wire logic [dvo_pkg::CH_W-1:0]   channel_one_input,
    input  wire logic [dvo_pkg::CH_W-1:0]   channel_two_input,
    input  wire logic                       link_de_input,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [dvo_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic      [23:0]                even_pixel_bus,
    output logic      [23:0]                odd_pixel_bus,
    output logic                            output_pixel_clock,
    output logic                            de_out,
    output logic                            hsync_out,
    output logic                            vsync_out,
    output logic                            ctl1_out,
    output logic                            ctl2_out,
    output logic                            pixel_out_en,
    output logic                            link_active_flag
);
    import dvo_pkg::*;

    localparam int IDLE_W = $clog2(IDLE_CYC + 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYC - 1);

    dvo_cfg_if cfg ();

    // register file on apb
    dvo_apb_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .cfg     (cfg.regs)
    );

    // ---------------- link clock domain ----------------
    logic [1:0]  lrst_q;
    logic        link_rst_n;
    logic [1:0]  cfg_l;
    logic        two_l;
    logic        stagger_select_n_n_l;
    dvo_phase_t  phase;
    dvo_phase_t  next_phase;
    logic        de_d;
    logic        hs_l;
    logic        vs_l;
    logic        c1_l;
    logic        c2_l;
    logic        next_hs;
    logic        next_vs;
    logic        next_c1;
    logic        next_c2;
    logic [23:0] pix;
    logic [23:0] even_store;
    logic [23:0] next_even_store;
    dvo_word_t   hold;
    dvo_word_t   next_hold;
    logic        hold_tgl;
    logic        next_hold_tgl;
    logic        de_tgl;
    logic        publish;

    // reset release aligned to the link clock
    always_ff @(posedge link_clock_input or negedge presetn) begin
        if (!presetn) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end
    assign link_rst_n = lrst_q[1];

    // mode bits brought over to the link clock
    dvo_sync #(.W(2)) u_cfg_sync (
        .clk   (link_clock_input),
        .rst_n (link_rst_n),
        .d     ({cfg.two_pix, cfg.stagger_select_n_n}),
        .q     (cfg_l)
    );
    assign two_l    = cfg_l[1];
    assign stagger_select_n_n_l = cfg_l[0];

    // colour bytes per channel
    assign pix = dvo_pack_pixel(channel_zero_input[7:0], channel_one_input[7:0],
                                channel_two_input[7:0]);

    // control recovery during blanking, pixel pairing, update publishing
    always_comb begin
        next_hs         = link_de_input ? hs_l : channel_zero_input[CH_C0_BIT];
        next_vs         = link_de_input ? vs_l : channel_zero_input[CH_C1_BIT];
        next_c1         = link_de_input ? c1_l : channel_one_input[CH_C1_BIT];
        next_c2         = link_de_input ? c2_l : channel_two_input[CH_C0_BIT];
        next_phase      = phase;
        next_even_store = even_store;
        next_hold       = hold;
        publish         = 1'b0;
        next_hold.two_pix = two_l;
        next_hold.stagger_select_n_n  = stagger_select_n_n_l;
        next_hold.de      = link_de_input;
        next_hold.hsync   = next_hs;
        next_hold.vsync   = next_vs;
        next_hold.ctl1    = next_c1;
        next_hold.ctl2    = next_c2;
        if (!two_l) begin
            // every pixel goes out on the even bus in turn, odd bus low
            publish        = 1'b1;
            next_phase     = PH_EVEN;
            next_hold.even = link_de_input ? pix : 24'h0;
            next_hold.odd  = 24'h0;
        end else if (link_de_input && !de_d) begin
            // first pixel of a line is always the even one
            next_even_store = pix;
            next_phase      = PH_ODD;
        end else begin
            case (phase)
                PH_EVEN: begin
                    next_even_store = link_de_input ? pix : 24'h0;
                    next_phase      = PH_ODD;
                end
                PH_ODD: begin
                    publish        = 1'b1;
                    next_hold.even = even_store;
                    next_hold.odd  = link_de_input ? pix : 24'h0;
                    next_phase     = PH_EVEN;
                end
                default: begin
                    next_phase = PH_EVEN;
                end
            endcase
        end
        if (!publish) begin
            next_hold = hold;
        end
        next_hold_tgl = hold_tgl ^ publish;
    end

    // link-side registers; de changes are counted as toggles
    always_ff @(posedge link_clock_input or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase      <= PH_EVEN;
            de_d       <= 1'b0;
            hs_l       <= 1'b0;
            vs_l       <= 1'b0;
            c1_l       <= 1'b0;
            c2_l       <= 1'b0;
            even_store <= 24'h0;
            hold       <= '0;
            hold_tgl   <= 1'b0;
            de_tgl     <= 1'b0;
        end else begin
            phase      <= next_phase;
            de_d       <= link_de_input;
            hs_l       <= next_hs;
            vs_l       <= next_vs;
            c1_l       <= next_c1;
            c2_l       <= next_c2;
            even_store <= next_even_store;
            hold       <= next_hold;
            hold_tgl   <= next_hold_tgl;
            de_tgl     <= de_tgl ^ (link_de_input ^ de_d);
        end
    end

    // ---------------- pclk domain ----------------
    logic [1:0]        tgl_s;
    logic              tgl_prev;
    logic              de_prev;
    logic              evt;
    logic              de_edge;
    logic              rise;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  next_period;
    logic [CNT_W-1:0]  half_pt;
    logic [23:0]       odd_pend;
    logic [23:0]       next_odd_pend;
    logic [23:0]       next_even_bus;
    logic [23:0]       next_odd_bus;
    logic              next_opclk;
    logic              out_two;
    logic              out_stagger_select_n_n;
    logic [IDLE_W-1:0] idle_cnt;
    logic [IDLE_W-1:0] next_idle_cnt;
    logic              next_link;
    dvo_word_t         outw;
    dvo_word_t         next_outw;

    // update toggle and de toggle brought over to pclk
    dvo_sync #(.W(2)) u_evt_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({hold_tgl, de_tgl}),
        .q     (tgl_s)
    );

    assign evt     = tgl_s[1] ^ tgl_prev;
    assign de_edge = tgl_s[0] ^ de_prev;
    assign half_pt = period >> 1;
    assign rise    = !evt && (cnt == half_pt - CNT_W'(1));

    // output clock and pixel buses; hold word is stable when evt fires
    always_comb begin
        next_cnt      = (cnt == {CNT_W{1'b1}}) ? cnt : cnt + CNT_W'(1);
        next_period   = period;
        next_even_bus = even_pixel_bus;
        next_odd_bus  = odd_pixel_bus;
        next_odd_pend = odd_pend;
        next_opclk    = output_pixel_clock;
        next_outw     = outw;
        if (evt) begin
            next_period   = next_cnt;
            next_cnt      = '0;
            next_outw     = hold;
            next_even_bus = hold.even;
            next_opclk    = 1'b0;
            if (hold.two_pix && !hold.stagger_select_n_n) begin
                next_odd_pend = hold.odd;
            end else begin
                next_odd_bus = hold.odd;
            end
        end else if (rise) begin
            next_opclk = 1'b1;
            if (out_two && !out_stagger_select_n_n) begin
                next_odd_bus = odd_pend;
            end
        end
    end
    assign out_two    = outw.two_pix;
    assign out_stagger_select_n_n = outw.stagger_select_n_n;

    // link activity from de switching within the idle window
    always_comb begin
        next_idle_cnt = idle_cnt;
        next_link     = link_active_flag;
        if (de_edge) begin
            next_idle_cnt = '0;
            next_link     = 1'b1;
        end else if (idle_cnt == IDLE_LAST) begin
            next_link     = 1'b0;
        end else begin
            next_idle_cnt = idle_cnt + IDLE_W'(1);
        end
    end

    // pclk registers; every top output except prdata, pready and pslverr of the register file comes from here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_prev           <= 1'b0;
            de_prev            <= 1'b0;
            cnt                <= '0;
            period             <= '0;
            odd_pend           <= 24'h0;
            outw               <= '0;
            even_pixel_bus     <= 24'h0;
            odd_pixel_bus      <= 24'h0;
            output_pixel_clock <= 1'b0;
            de_out             <= 1'b0;
            hsync_out          <= 1'b0;
            vsync_out          <= 1'b0;
            ctl1_out           <= 1'b0;
            ctl2_out           <= 1'b0;
            pixel_out_en       <= 1'b0;
            idle_cnt           <= '0;
            link_active_flag   <= 1'b0;
        end else begin
            tgl_prev           <= tgl_s[1];
            de_prev            <= tgl_s[0];
            cnt                <= next_cnt;
            period             <= next_period;
            odd_pend           <= next_odd_pend;
            outw               <= next_outw;
            even_pixel_bus     <= next_even_bus;
            odd_pixel_bus      <= next_odd_bus;
            output_pixel_clock <= next_opclk;
            de_out             <= next_outw.de;
            hsync_out          <= next_outw.hsync;
            vsync_out          <= next_outw.vsync;
            ctl1_out           <= next_outw.ctl1;
            ctl2_out           <= next_outw.ctl2;
            pixel_out_en       <= cfg.pdo_n;
            idle_cnt           <= next_idle_cnt;
            link_active_flag   <= next_link;
        end
    end
    assign cfg.link_active = link_active_flag;

    // ---------------- checks ----------------
    chk_onepix_even_bus: assert property (@(posedge link_clock_input)
        disable iff (!link_rst_n)
        (!two_l && link_de_input) |=> (hold.even == $past(pix) && hold.odd == 24'h0))
        else $error("one-pixel mode pixel not placed on even bus");
    chk_twopix_pairing: assert property (@(posedge link_clock_input)
        disable iff (!link_rst_n)
        (two_l && phase == PH_ODD && link_de_input && de_d)
        |=> (hold.even == $past(even_store) && hold.odd == $past(pix)))
        else $error("two-pixel pair assembled wrongly");
    chk_blank_controls: assert property (@(posedge link_clock_input)
        disable iff (!link_rst_n)
        !link_de_input |=> (hs_l == $past(channel_zero_input[CH_C0_BIT])
            && vs_l == $past(channel_zero_input[CH_C1_BIT])
            && c1_l == $past(channel_one_input[CH_C1_BIT])
            && c2_l == $past(channel_two_input[CH_C0_BIT])))
        else $error("control signals not recovered during blanking");
    chk_odd_low_onepix: assert property (@(posedge pclk) disable iff (!presetn)
        !out_two |-> odd_pixel_bus == 24'h0)
        else $error("odd bus not low in one-pixel mode");
    chk_even_with_clock: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(even_pixel_bus) |-> $fell(output_pixel_clock) || !output_pixel_clock)
        else $error("even bus changed while output clock high");
    chk_stagger_odd_late: assert property (@(posedge pclk) disable iff (!presetn)
        (out_two && !out_stagger_select_n_n && $changed(odd_pixel_bus)) |-> $rose(output_pixel_clock))
        else $error("staggered odd bus not moved at clock midpoint");
    chk_odd_together: assert property (@(posedge pclk) disable iff (!presetn)
        (evt && hold.two_pix && hold.stagger_select_n_n) |=> odd_pixel_bus == $past(hold.odd))
        else $error("odd bus not updated with even bus");
    chk_link_rise: assert property (@(posedge pclk) disable iff (!presetn)
        de_edge |=> link_active_flag)
        else $error("link flag not raised on de switching");
    chk_link_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (!de_edge && idle_cnt == IDLE_LAST) |=> !link_active_flag)
        else $error("link flag not dropped after idle window");
    chk_powerdown_oe: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.pdo_n |=> !pixel_out_en)
        else $error("drivers enabled during output powerdown");

    cov_stagger_odd: cover property (@(posedge pclk) disable iff (!presetn)
        rise && out_two && !out_stagger_select_n_n);
    cov_link_drop: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(link_active_flag));
    cov_twopix_pub: cover property (@(posedge link_clock_input) disable iff (!link_rst_n)
        two_l && phase == PH_ODD && link_de_input);
endmodule : dvo_formatter
`default_nettype wire

// >>> verif/dvo_link_src.sv
// link-side source model: recovered channel words and de
`timescale 1ns/1ps
`default_nettype none
module dvo_link_src #(
    parameter int ACT = 16,
    parameter int BLK = 8
) (
    input  wire logic       link_clk,
    input  wire logic       run,
    output logic      [9:0] ch0,
    output logic      [9:0] ch1,
    output logic      [9:0] ch2,
    output logic            de
);
    logic [7:0] pos = 8'h00;
    logic       act;
    assign act = run && (pos < 8'(ACT));
    // blanking: hsync 1, vsync 0, ctl1 1, ctl2 1, byte is filler
    always @(posedge link_clk) begin
        pos <= (pos == 8'(ACT + BLK - 1)) ? 8'h00 : pos + 8'h01;
        de  <= act;
        ch0 <= act ? {2'b00, pos} : {2'b01, 8'h5a};
        ch1 <= act ? {2'b00, pos ^ 8'h40} : {2'b10, 8'h5a};
        ch2 <= act ? {2'b00, pos ^ 8'h80} : {2'b01, 8'h5a};
    end
endmodule : dvo_link_src
`default_nettype wire

// >>> verif/tb_dvo_formatter.sv
// self-checking bench of the pixel output formatter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module tb_dvo_formatter;
    import dvo_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, lclk = 1'b0, run = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, opc, pen, de_o, hs, vs, c1, c2, flag, de;
    logic [9:0]  ch0, ch1, ch2;
    logic [23:0] ev, od;
    int          n_errors = 0, n_compared = 0;
    realtime     t0;

    always #2.5 pclk = ~pclk;
    // link clock, offset in phase from pclk
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end

    dvo_link_src src (.link_clk(lclk), .run(run), .ch0(ch0), .ch1(ch1), .ch2(ch2), .de(de));
    dvo_formatter #(.IDLE_CYC(400)) uut (.pclk(pclk), .presetn(presetn),
        .link_clock_input(lclk), .channel_zero_input(ch0), .channel_one_input(ch1),
        .channel_two_input(ch2), .link_de_input(de), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .even_pixel_bus(ev), .odd_pixel_bus(od),
        .output_pixel_clock(opc), .de_out(de_o), .hsync_out(hs), .vsync_out(vs),
        .ctl1_out(c1), .ctl2_out(c2), .pixel_out_en(pen), .link_active_flag(flag));

    // expected pixel k: blue k, green and red with top bits flipped
    function automatic logic [23:0] px(input logic [7:0] k);
        return {k ^ 8'h80, k ^ 8'h40, k};
    endfunction : px

    // one apb transfer, result left in q and e
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write control, then wait for a whole line start in the new mode
    task automatic cfg(input logic [31:0] d);
        apb(1'b1, REG_CTRL, d);
        @(negedge de_o);
        @(posedge de_o);
        #1;
    endtask : cfg

    // output clock period, skipping the first possibly short one
    task automatic per(input realtime p);
        @(negedge opc);
        @(negedge opc);
        t0 = $realtime;
        @(negedge opc);
        `CHK(($realtime - t0 > p - 6.0) && ($realtime - t0 < p + 6.0), 1'b1)
    endtask : per

    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(q, 32'h6)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(e, 1'b1)
        $display("test regs done");
        cfg(32'h6);
        `CHK({od, ev}, {24'h0, px(8'h00)})
        @(ev);
        #1;
        `CHK(ev, px(8'h01))
        @(negedge de_o);
        #1;
        `CHK({hs, vs, c1, c2}, 4'b1011)
        per(48.0);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK({q[0], flag}, 2'b11)
        $display("test one pixel done");
        cfg(32'h7);
        `CHK({od, ev}, {px(8'h01), px(8'h00)})
        per(96.0);
        cfg(32'h5);
        `CHK(od, 24'h0)
        @(posedge opc);
        #1;
        `CHK(od, px(8'h01))
        $display("test two pixel done");
        apb(1'b1, REG_CTRL, 32'h3);
        repeat (2) @(posedge pclk);
        #1;
        `CHK({pen, flag}, 2'b01)
        // system copies the link flag into the output powerdown bit
        apb(1'b1, REG_CTRL, {29'h0, flag, 2'h3});
        @(posedge pclk);
        run <= 1'b0;
        repeat (500) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK({q[0], flag, pen}, 3'b001)
        apb(1'b1, REG_CTRL, {29'h0, q[0], 2'h3});
        repeat (2) @(posedge pclk);
        #1;
        `CHK(pen, 1'b0)
        $display("test powerdown and idle done");
        test_done();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done();
    end
endmodule : tb_dvo_formatter
`default_nettype wire
